// ===== design/dpi_pkg.sv
// package for the ddr2 power-up initialisation pair: command codes, bank codes,
// address field positions and timing figures shared by both ends.
// assumes a 125 MHz system clock on both ends.
package dpi_pkg;
    // system clock period in picoseconds
    localparam int unsigned CLK_PS = 8000;
    // widths of the command bus
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned BANK_W = 3;
    // clock stable wait before cke, in microseconds
    localparam int unsigned T_CLK_STABLE_US = 200;
    localparam int unsigned CLK_STABLE_CYC = (T_CLK_STABLE_US * 1000000 + CLK_PS - 1) / CLK_PS;
    // nop period after cke high, in nanoseconds
    localparam int unsigned T_CKE_NOP_NS = 400;
    localparam int unsigned CKE_NOP_CYC = (T_CKE_NOP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // link clocks between dll reset and calibration step
    localparam int unsigned DLL_LOCK_CLKS = 200;
    // link clocks between commands (mode register cycle time and others)
    localparam int unsigned CMD_GAP_CLKS = 4;
    // least number of auto-refresh commands
    localparam int unsigned MIN_REFRESH = 2;
    // link clock divider: half period in system clocks (64 ns link period)
    localparam int unsigned LINK_HALF = 4;
    // command codes {ras_n, cas_n, we_n} with cs_n low
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_MRS = 3'h0;
    // bank codes selecting each mode register
    localparam logic [2:0] BANK_MR = 3'h0;
    localparam logic [2:0] BANK_EMR1 = 3'h1;
    localparam logic [2:0] BANK_EMR2 = 3'h2;
    localparam logic [2:0] BANK_EMR3 = 3'h3;
    // address bit positions
    localparam int unsigned A_DLL_DIS = 0;
    localparam int unsigned A_PRE_ALL = 10;
    localparam int unsigned A_DLL_RST = 8;
    localparam int unsigned A_OCD_LO = 7;
    localparam int unsigned A_OCD_HI = 9;
    localparam int unsigned A_TOP = 13;
    // calibration field values
    localparam logic [2:0] OCD_EXIT = 3'h0;
    localparam logic [2:0] OCD_DEFAULT = 3'h7;
endpackage

// ===== design/dpi_link_if.sv
// interface carrying the ddr2 command pins between controller and device end.
// assumes both ends share sys_clk; the link clock itself is a data signal here.
`timescale 1ns/1ps
interface dpi_link_if;
    logic ck; // link clock driven by the controller
    logic cke; // clock enable
    logic odt; // termination control
    logic cs_n; // chip select, low active
    logic ras_n; // row strobe
    logic cas_n; // column strobe
    logic we_n; // write enable
    logic [2:0] ba; // bank bits
    logic [13:0] addr; // address bits
    modport ctrl (output ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
    modport dev (input ck, cke, odt, cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface

// ===== design/dpi_ctrl.sv
// controller end: divides sys_clk into the link clock and walks the ddr2
// power-up sequence, changing command pins on link clock falling edges.
// assumes the device end samples commands on rising link clock edges.
`timescale 1ns/1ps
module dpi_ctrl #(
    parameter int unsigned STABLE_CYC = dpi_pkg::CLK_STABLE_CYC, // clock stable wait
    parameter int unsigned NOP_CYC = dpi_pkg::CKE_NOP_CYC, // nop wait after cke
    parameter int unsigned N_REFRESH = dpi_pkg::MIN_REFRESH, // refresh count
    parameter logic [13:0] MR_OPER = 14'h0632, // main register operating value
    parameter logic [13:0] EMR1_OPER = 14'h0000, // register one operating fields
    parameter logic [13:0] EMR2_VAL = 14'h0000, // register two value
    parameter logic [13:0] EMR3_VAL = 14'h0000 // register three value
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    output logic ready,
    dpi_link_if.ctrl link
);
    import dpi_pkg::*;

    // sequence states
    typedef enum logic [3:0] {
        S_PWR, S_STABLE, S_NOP, S_PRE1, S_EMR2, S_EMR3, S_DLLEN, S_DLLRST,
        S_PRE2, S_REF, S_MR, S_LOCK, S_OCDDEF, S_OCDEXIT, S_DONE
    } dpi_cstate_t;

    dpi_cstate_t st_r, st_nxt; // sequence state
    logic [31:0] wait_r, wait_nxt; // wait counter in sys clocks or link clocks
    logic [7:0] ref_r, ref_nxt; // refreshes issued
    logic [2:0] div_r, div_nxt; // link clock divider
    logic ck_r, ck_nxt; // link clock
    logic cke_r, cke_nxt;
    logic rdy_r, rdy_nxt;
    logic [2:0] cmd_r, cmd_nxt; // ras, cas, we
    logic [2:0] ba_r, ba_nxt;
    logic [13:0] a_r, a_nxt;
    logic fall; // link clock about to fall

    assign fall = ck_r && (div_r == 3'(LINK_HALF - 1));

    // next-state logic for divider and sequence
    always_comb begin
        div_nxt = (div_r == 3'(LINK_HALF - 1)) ? 3'h0 : div_r + 3'h1;
        ck_nxt = (div_r == 3'(LINK_HALF - 1)) ? ~ck_r : ck_r;
        st_nxt = st_r;
        wait_nxt = wait_r;
        ref_nxt = ref_r;
        cke_nxt = cke_r;
        rdy_nxt = rdy_r;
        cmd_nxt = cmd_r;
        ba_nxt = ba_r;
        a_nxt = a_r;
        case (st_r)
            S_PWR: begin
                // cke low, nop, until software starts
                if (start) begin
                    st_nxt = S_STABLE;
                    wait_nxt = 32'h0;
                end
            end
            S_STABLE: begin
                // clock runs, cke still low
                wait_nxt = wait_r + 32'h1;
                if (wait_r >= 32'(STABLE_CYC) && fall) begin
                    cke_nxt = 1'b1;
                    st_nxt = S_NOP;
                    wait_nxt = 32'h0;
                end
            end
            default: begin
                // command steps advance on falling link edges
                if (st_r == S_NOP) begin
                    wait_nxt = wait_r + 32'h1;
                end
                if (fall) begin
                    cmd_nxt = CMD_NOP;
                    ba_nxt = 3'h0;
                    a_nxt = 14'h0;
                    if (st_r != S_NOP) begin
                        wait_nxt = wait_r + 32'h1; // link clocks since command; not cleared from S_DLLRST through S_LOCK, so counts from the dll reset command
                    end
                    case (st_r)
                        S_NOP: if (wait_r >= 32'(NOP_CYC)) begin
                            cmd_nxt = CMD_PRE;
                            a_nxt[A_PRE_ALL] = 1'b1;
                            st_nxt = S_PRE1;
                            wait_nxt = 32'h0;
                        end
                        S_PRE1: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_EMR2;
                            a_nxt = EMR2_VAL;
                            st_nxt = S_EMR2;
                            wait_nxt = 32'h0;
                        end
                        S_EMR2: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_EMR3;
                            a_nxt = EMR3_VAL;
                            st_nxt = S_EMR3;
                            wait_nxt = 32'h0;
                        end
                        S_EMR3: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_EMR1;
                            a_nxt = EMR1_OPER;
                            a_nxt[A_DLL_DIS] = 1'b0;
                            a_nxt[A_OCD_HI:A_OCD_LO] = OCD_EXIT;
                            a_nxt[A_TOP] = 1'b0;
                            st_nxt = S_DLLEN;
                            wait_nxt = 32'h0;
                        end
                        S_DLLEN: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_MR;
                            a_nxt = MR_OPER;
                            a_nxt[A_DLL_RST] = 1'b1;
                            a_nxt[A_TOP] = 1'b0;
                            st_nxt = S_DLLRST;
                            wait_nxt = 32'h0;
                        end
                        S_DLLRST: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_PRE;
                            a_nxt[A_PRE_ALL] = 1'b1;
                            st_nxt = S_PRE2;
                        end
                        S_PRE2: if (wait_r >= 32'(2 * CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_REF;
                            ref_nxt = 8'h1;
                            st_nxt = S_REF;
                        end
                        S_REF: if (wait_r >= 32'((ref_r + 1) * CMD_GAP_CLKS * 4)) begin
                            if (ref_r < 8'(N_REFRESH)) begin
                                cmd_nxt = CMD_REF;
                                ref_nxt = ref_r + 8'h1;
                            end else begin
                                cmd_nxt = CMD_MRS;
                                ba_nxt = BANK_MR;
                                a_nxt = MR_OPER;
                                a_nxt[A_DLL_RST] = 1'b0;
                                st_nxt = S_MR;
                            end
                        end
                        S_MR: st_nxt = S_LOCK;
                        S_LOCK: if (wait_r >= 32'(DLL_LOCK_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_EMR1;
                            a_nxt = EMR1_OPER;
                            a_nxt[A_OCD_HI:A_OCD_LO] = OCD_DEFAULT;
                            st_nxt = S_OCDDEF;
                            wait_nxt = 32'h0;
                        end
                        S_OCDDEF: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            cmd_nxt = CMD_MRS;
                            ba_nxt = BANK_EMR1;
                            a_nxt = EMR1_OPER;
                            a_nxt[A_OCD_HI:A_OCD_LO] = OCD_EXIT;
                            st_nxt = S_OCDEXIT;
                            wait_nxt = 32'h0;
                        end
                        S_OCDEXIT: if (wait_r >= 32'(CMD_GAP_CLKS)) begin
                            st_nxt = S_DONE;
                            rdy_nxt = 1'b1;
                        end
                        default: begin
                            // done: hold nop
                        end
                    endcase
                end
            end
        endcase
    end

    // register all state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r <= S_PWR;
            wait_r <= 32'h0;
            ref_r <= 8'h0;
            div_r <= 3'h0;
            ck_r <= 1'b0;
            cke_r <= 1'b0;
            rdy_r <= 1'b0;
            cmd_r <= CMD_NOP;
            ba_r <= 3'h0;
            a_r <= 14'h0;
        end else begin
            st_r <= st_nxt;
            wait_r <= wait_nxt;
            ref_r <= ref_nxt;
            div_r <= div_nxt;
            ck_r <= ck_nxt;
            cke_r <= cke_nxt;
            rdy_r <= rdy_nxt;
            cmd_r <= cmd_nxt;
            ba_r <= ba_nxt;
            a_r <= a_nxt;
        end
    end

    // pins straight from flip-flops, odt and cs_n tied low
    assign ready = rdy_r;
    assign link.ck = ck_r;
    assign link.cke = cke_r;
    assign link.odt = 1'b0;
    assign link.cs_n = 1'b0;
    assign link.ras_n = cmd_r[2];
    assign link.cas_n = cmd_r[1];
    assign link.we_n = cmd_r[0];
    assign link.ba = ba_r;
    assign link.addr = a_r;
endmodule

// ===== design/dpi_dev.sv
// device end: samples the command pins on rising link clock edges found with
// sys_clk, tracks the power-up sequence and stores the mode registers.
// assumes the controller changes pins away from the rising link edge.
`timescale 1ns/1ps
module dpi_dev (
    input wire logic sys_clk,
    input wire logic nrst,
    dpi_link_if.dev link,
    output logic ready,
    output logic seq_err,
    output logic [13:0] mr_val,
    output logic [13:0] emr1_val,
    output logic [13:0] emr2_val,
    output logic [13:0] emr3_val
);
    import dpi_pkg::*;

    // progress of the power-up sequence
    typedef enum logic [3:0] {
        D_IDLE, D_PRE1, D_EMR2, D_EMR3, D_DLLEN, D_DLLRST, D_PRE2, D_REF,
        D_MR, D_OCDDEF, D_READY
    } dpi_dstate_t;

    logic [25:0] s1_r, s2_r; // two-stage synchronisers for all pins
    logic ck_d_r; // previous synchronised link clock
    dpi_dstate_t st_r, st_nxt;
    logic [7:0] ref_r, ref_nxt; // refreshes seen
    logic [7:0] lk_r, lk_nxt; // link clocks since dll reset
    logic err_r, err_nxt;
    logic [13:0] mr_r, mr_nxt, e1_r, e1_nxt, e2_r, e2_nxt, e3_r, e3_nxt;
    logic rise, cke, cmd_ok, is_mrs, is_pre, is_ref;
    logic [2:0] bank;
    logic [13:0] a;

    // synchronise pins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s1_r <= 26'h0;
            s2_r <= 26'h0;
            ck_d_r <= 1'b0;
        end else begin
            s1_r <= {link.ck, link.cke, link.cs_n, link.ras_n, link.cas_n, link.we_n,
                     link.ba, link.addr, link.odt, 2'h0};
            s2_r <= s1_r;
            ck_d_r <= s2_r[25];
        end
    end

    // decode of the sampled command
    assign rise = s2_r[25] && !ck_d_r;
    assign cke = s2_r[24];
    assign cmd_ok = !s2_r[23]; // chip select low
    assign bank = s2_r[19:17];
    assign a = s2_r[16:3];
    assign is_mrs = rise && cke && cmd_ok && (s2_r[22:20] == CMD_MRS);
    assign is_pre = rise && cke && cmd_ok && (s2_r[22:20] == CMD_PRE) && a[A_PRE_ALL];
    assign is_ref = rise && cke && cmd_ok && (s2_r[22:20] == CMD_REF);

    // sequence tracking and register writes
    always_comb begin
        st_nxt = st_r;
        ref_nxt = ref_r;
        lk_nxt = (rise && lk_r != 8'hff) ? lk_r + 8'h1 : lk_r;
        err_nxt = err_r;
        mr_nxt = mr_r;
        e1_nxt = e1_r;
        e2_nxt = e2_r;
        e3_nxt = e3_r;
        // whole register replaced, array untouched
        if (is_mrs) begin
            case (bank)
                BANK_MR: mr_nxt = a;
                BANK_EMR1: e1_nxt = a;
                BANK_EMR2: e2_nxt = a;
                BANK_EMR3: e3_nxt = a;
                default: err_nxt = 1'b1;
            endcase
        end
        case (st_r)
            D_IDLE: if (is_pre) st_nxt = D_PRE1;
            D_PRE1: if (is_mrs) begin
                if (bank == BANK_EMR2) st_nxt = D_EMR2; else err_nxt = 1'b1;
            end
            D_EMR2: if (is_mrs) begin
                if (bank == BANK_EMR3) st_nxt = D_EMR3; else err_nxt = 1'b1;
            end
            D_EMR3: if (is_mrs) begin
                if (bank == BANK_EMR1 && !a[A_DLL_DIS]) st_nxt = D_DLLEN;
                else err_nxt = 1'b1;
            end
            D_DLLEN: if (is_mrs) begin
                if (bank == BANK_MR && a[A_DLL_RST]) begin
                    st_nxt = D_DLLRST;
                    lk_nxt = 8'h0;
                end else err_nxt = 1'b1;
            end
            D_DLLRST: if (is_pre) st_nxt = D_PRE2;
            else if (is_mrs || is_ref) err_nxt = 1'b1;
            D_PRE2: if (is_ref) begin
                st_nxt = D_REF;
                ref_nxt = 8'h1;
            end else if (is_mrs) err_nxt = 1'b1;
            D_REF: if (is_ref) ref_nxt = ref_r + 8'h1;
            else if (is_mrs) begin
                if (ref_r >= 8'(MIN_REFRESH) && bank == BANK_MR && !a[A_DLL_RST])
                    st_nxt = D_MR;
                else err_nxt = 1'b1;
            end
            D_MR: if (is_mrs) begin
                if (bank == BANK_EMR1 && a[A_OCD_HI:A_OCD_LO] == OCD_DEFAULT
                        && lk_r >= 8'(DLL_LOCK_CLKS)) st_nxt = D_OCDDEF;
                else err_nxt = 1'b1;
            end
            D_OCDDEF: if (is_mrs) begin
                if (bank == BANK_EMR1 && a[A_OCD_HI:A_OCD_LO] == OCD_EXIT) st_nxt = D_READY;
                else err_nxt = 1'b1;
            end
            default: begin
                // ready: later writes allowed, sequence stays done
            end
        endcase
    end

    // register sequence state
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_r <= D_IDLE;
            ref_r <= 8'h0;
            lk_r <= 8'h0;
            err_r <= 1'b0;
            mr_r <= 14'h0;
            e1_r <= 14'h0;
            e2_r <= 14'h0;
            e3_r <= 14'h0;
        end else begin
            st_r <= st_nxt;
            ref_r <= ref_nxt;
            lk_r <= lk_nxt;
            err_r <= err_nxt;
            mr_r <= mr_nxt;
            e1_r <= e1_nxt;
            e2_r <= e2_nxt;
            e3_r <= e3_nxt;
        end
    end

    // ready only after the complete sequence
    logic rdy_r;
    always_ff @(posedge sys_clk) begin
        if (!nrst) rdy_r <= 1'b0;
        else rdy_r <= (st_nxt == D_READY) && !err_nxt;
    end
    assign ready = rdy_r;
    assign seq_err = err_r;
    assign mr_val = mr_r;
    assign emr1_val = e1_r;
    assign emr2_val = e2_r;
    assign emr3_val = e3_r;
endmodule

// ===== testbench/dpi_link_sva.sv
// checker for the ddr2 power-up command link between the two ends.
// assumes it sits beside the link interface, on the shared sys_clk.
`timescale 1ns/1ps
module dpi_link_sva
    import dpi_pkg::*;
#(
    parameter int unsigned STABLE_CYC = 200, // clock stable wait
    parameter int unsigned NOP_CYC = 50, // nop wait after cke
    parameter int unsigned N_REFRESH = 2 // refresh count
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic ck,
    input wire logic cke,
    input wire logic odt,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic ready
);
    logic [2:0] cmd; // strobe code
    logic issue; // command taken at a link rise
    logic emr1; // write to register one
    logic ck_r; // link clock one sysclk ago
    logic [31:0] low_cnt_r; // sysclks with cke low
    logic [31:0] hi_cnt_r; // sysclks with cke high
    logic [15:0] gap_r; // link rises since last command
    logic [15:0] lock_r; // link rises since dll reset
    logic [7:0] ref_cnt_r; // refreshes since precharge
    logic dflt_r; // ocd default write seen
    logic exit_r; // ocd exit write seen after default
    assign cmd = {ras_n, cas_n, we_n};
    assign issue = ck && !ck_r && cke && !cs_n && cmd != CMD_NOP;
    assign emr1 = issue && cmd == CMD_MRS && ba == BANK_EMR1;
    // bookkeeping of waits and counts along the sequence
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ck_r <= 1'b0;
            low_cnt_r <= '0;
            hi_cnt_r <= '0;
            gap_r <= 16'hffff;
            lock_r <= '0;
            ref_cnt_r <= '0;
            dflt_r <= 1'b0;
            exit_r <= 1'b0;
        end else begin
            ck_r <= ck;
            low_cnt_r <= cke ? low_cnt_r : low_cnt_r + 1;
            hi_cnt_r <= cke ? hi_cnt_r + 1 : hi_cnt_r;
            if (issue) begin
                gap_r <= 16'h1;
            end else if (ck && !ck_r && gap_r != 16'hffff) begin
                gap_r <= gap_r + 1;
            end
            if (issue && cmd == CMD_MRS && ba == BANK_MR && addr[A_DLL_RST]) begin
                lock_r <= 16'h1;
            end else if (ck && !ck_r && lock_r != '0 && lock_r != 16'hffff) begin
                lock_r <= lock_r + 1;
            end
            if (issue && cmd == CMD_PRE) begin
                ref_cnt_r <= '0;
            end else if (issue && cmd == CMD_REF) begin
                ref_cnt_r <= ref_cnt_r + 1;
            end
            dflt_r <= dflt_r || (emr1 && addr[9:7] == OCD_DEFAULT);
            exit_r <= exit_r || (emr1 && addr[9:7] == OCD_EXIT && dflt_r);
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    AST_ODT_LOW: assert property (odt == 1'b0)
        else $error("termination control raised");
    AST_CKE_HOLD: assert property ($rose(cke) |-> low_cnt_r >= STABLE_CYC)
        else $error("clock enable raised too early");
    AST_CKE_NOP: assert property ($rose(cke) |-> cmd == CMD_NOP)
        else $error("clock enable raised without nop");
    AST_NOP_WAIT: assert property (issue |-> hi_cnt_r >= NOP_CYC)
        else $error("command inside the nop period");
    AST_CMD_ON_FALL: assert property (
        $changed({cke, cmd, ba, addr}) |-> !ck && $past(ck))
        else $error("command pins moved away from a falling link edge");
    AST_MRD_GAP: assert property (issue |-> gap_r >= CMD_GAP_CLKS)
        else $error("commands too close together");
    AST_PRE_ALL: assert property (issue && cmd == CMD_PRE |-> addr[A_PRE_ALL])
        else $error("precharge without all-bank bit");
    AST_REFRESH: assert property (
        issue && cmd == CMD_MRS && ba == BANK_MR && !addr[A_DLL_RST] |-> ref_cnt_r >= N_REFRESH)
        else $error("too few refreshes before operating write");
    AST_DLL_LOCK: assert property (
        emr1 && addr[9:7] == OCD_DEFAULT |-> lock_r >= DLL_LOCK_CLKS)
        else $error("ocd default too soon after dll reset");
    AST_EMR1_OCD: assert property (emr1 |-> !addr[A_DLL_DIS] &&
        (addr[9:7] == OCD_EXIT || addr[9:7] == OCD_DEFAULT))
        else $error("register one write with bad dll or ocd field");
    AST_MR_TOP: assert property (
        issue && cmd == CMD_MRS && ba == BANK_MR |-> !addr[A_TOP])
        else $error("main register write with top bit set");
    AST_READY: assert property ($rose(ready) |-> exit_r && cmd == CMD_NOP)
        else $error("ready before the full sequence");
endmodule

// ===== testbench/ddr2_powerup_init_sequence_bench.sv
// bench for the ddr2 power-up pair: controller against device end, plus a
// second device end driven out of order by the bench itself.
// assumes both ends and the checker share sys_clk and nrst.
`timescale 1ns/1ps
module ddr2_powerup_init_sequence_bench;
    import dpi_pkg::*;
    localparam int N_REF = 3; // one above the least count
    localparam logic [13:0] MR_V = 14'h0632; // main register value
    localparam logic [13:0] EMR1_V = 14'h0046; // register one operating fields
    localparam logic [13:0] EMR2_V = 14'h0080; // register two value
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic start = 1'b0;
    logic c_ready, d_ready, d_err, f_err;
    logic [13:0] d_mr, d_e1, d_e2, d_e3, f_mr;
    int bad_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'h85f6e2a4; // fixed seed
    logic ck_q = 1'b0; // link clock one sysclk ago
    logic [19:0] seen_q[$]; // commands seen on the wire
    dpi_link_if l_link();
    dpi_link_if l_flt();
    dpi_ctrl #(.STABLE_CYC(200), .N_REFRESH(N_REF), .MR_OPER(MR_V), .EMR1_OPER(EMR1_V),
        .EMR2_VAL(EMR2_V), .EMR3_VAL(14'h0000)) i_dpi_ctrl (.sys_clk(sys_clk), .nrst(nrst),
        .start(start), .ready(c_ready), .link(l_link));
    dpi_dev i_dpi_dev (.sys_clk(sys_clk), .nrst(nrst), .link(l_link), .ready(d_ready),
        .seq_err(d_err), .mr_val(d_mr), .emr1_val(d_e1), .emr2_val(d_e2), .emr3_val(d_e3));
    dpi_dev i_dpi_dev_flt (.sys_clk(sys_clk), .nrst(nrst), .link(l_flt), .ready(),
        .seq_err(f_err), .mr_val(f_mr), .emr1_val(), .emr2_val(), .emr3_val());
    dpi_link_sva #(.STABLE_CYC(200), .NOP_CYC(CKE_NOP_CYC), .N_REFRESH(N_REF)) i_dpi_link_sva (
        .sys_clk(sys_clk), .nrst(nrst), .ck(l_link.ck), .cke(l_link.cke), .odt(l_link.odt),
        .cs_n(l_link.cs_n), .ras_n(l_link.ras_n), .cas_n(l_link.cas_n), .we_n(l_link.we_n),
        .ba(l_link.ba), .addr(l_link.addr), .ready(c_ready));
    always #4 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction
    // keep only the pins that matter for each command
    function automatic logic [19:0] mask_w(input logic [19:0] w);
        if (w[19:17] == CMD_MRS) return w;
        if (w[19:17] == CMD_PRE) return {w[19:17], 6'h0, w[A_PRE_ALL], 10'h0};
        return {w[19:17], 17'h0};
    endfunction
    // expected i-th command of the power-up walk
    function automatic logic [19:0] exp_w(input int i);
        if (i == 0 || i == 5) return {CMD_PRE, 3'h0, 14'h0400};
        if (i == 1) return {CMD_MRS, BANK_EMR2, EMR2_V};
        if (i == 2) return {CMD_MRS, BANK_EMR3, 14'h0000};
        if (i == 3) return {CMD_MRS, BANK_EMR1, EMR1_V};
        if (i == 4) return {CMD_MRS, BANK_MR, MR_V | 14'h0100};
        if (i < 6 + N_REF) return {CMD_REF, 17'h0};
        if (i == 6 + N_REF) return {CMD_MRS, BANK_MR, MR_V};
        if (i == 7 + N_REF) return {CMD_MRS, BANK_EMR1, EMR1_V | 14'h0380};
        return {CMD_MRS, BANK_EMR1, EMR1_V};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one command on the faulty link, then nop with the address pins moved
    task automatic flt_cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
        @(posedge sys_clk);
        {l_flt.ras_n, l_flt.cas_n, l_flt.we_n} <= c;
        l_flt.ba <= b;
        l_flt.addr <= a;
        repeat (LINK_HALF) @(posedge sys_clk);
        l_flt.ck <= 1'b1;
        repeat (LINK_HALF) @(posedge sys_clk);
        l_flt.ck <= 1'b0;
        {l_flt.ras_n, l_flt.cas_n, l_flt.we_n} <= CMD_NOP;
        l_flt.addr <= ~a;
        repeat (8 * LINK_HALF) @(posedge sys_clk);
    endtask
    // wire monitor and hang limit
    always @(posedge sys_clk) begin
        ck_q <= l_link.ck;
        cyc <= cyc + 1;
        if (l_link.ck && !ck_q && l_link.cke && !l_link.cs_n
            && {l_link.ras_n, l_link.cas_n, l_link.we_n} != CMD_NOP) begin
            seen_q.push_back(mask_w({l_link.ras_n, l_link.cas_n, l_link.we_n, l_link.ba,
                l_link.addr}));
        end
        if (cyc == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    initial begin
        logic [13:0] ra;
        l_flt.ck = 1'b0;
        l_flt.cke = 1'b0;
        l_flt.odt = 1'b0;
        l_flt.cs_n = 1'b0;
        {l_flt.ras_n, l_flt.cas_n, l_flt.we_n} = CMD_NOP;
        l_flt.ba = 3'h0;
        l_flt.addr = 14'h0000;
        repeat (2) @(posedge sys_clk);
        check(l_link.cke, 1'b0);
        check(l_link.odt, 1'b0);
        check({c_ready, d_ready, d_err}, 3'h0);
        nrst <= 1'b1;
        lfsr = lfsr_next(lfsr);
        repeat (lfsr[3:0]) @(posedge sys_clk);
        start <= 1'b1;
        for (int i = 0; i < 8000 && !(c_ready === 1'b1 && d_ready === 1'b1); i++) begin
            @(posedge sys_clk);
        end
        check({c_ready, d_ready, d_err}, 3'h6);
        check(32'(seen_q.size()), 32'(9 + N_REF));
        for (int i = 0; i < 9 + N_REF && i < seen_q.size(); i++) begin
            check(seen_q[i], exp_w(i));
        end
        check(d_mr, MR_V);
        check(d_e1, EMR1_V);
        check({d_e2, d_e3}, {EMR2_V, 14'h0000});
        // second link: precharge-all is legal, then main-register writes where
        // register two is due: flagged, still stored
        @(posedge sys_clk);
        l_flt.cke <= 1'b1;
        flt_cmd(CMD_PRE, BANK_MR, 14'h0400);
        check(f_err, 1'b0);
        for (int k = 0; k < 3; k++) begin
            lfsr = lfsr_next(lfsr);
            ra = lfsr[13:0];
            flt_cmd(CMD_MRS, BANK_MR, ra);
            check(f_err, 1'b1);
            check(f_mr, ra);
        end
        print_verdict();
    end
endmodule
